// file: src/tdbd_defines.vh
// Register offsets, field positions and reset values of the two-channel byte DMA
`ifndef TDBD_DEFINES_VH
`define TDBD_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TDBD_OFS_STATUS 8'h3f
`define TDBD_OFS_MODE 8'h40
`define TDBD_OFS_SRC_LO 8'h41
`define TDBD_OFS_SRC_HI 8'h42
`define TDBD_OFS_DST_LO 8'h43
`define TDBD_OFS_DST_HI 8'h44
`define TDBD_OFS_CNT_LO 8'h45
`define TDBD_OFS_CNT_HI 8'h46
`define TDBD_OFS_RQC0 8'h47
`define TDBD_OFS_RQC1 8'h48

// ****************************************************************
// Status/config fields
// ****************************************************************
`define TDBD_SC_UF0 0
`define TDBD_SC_SF0 1
`define TDBD_SC_UF1 2
`define TDBD_SC_SF1 3
`define TDBD_SC_SUSP_ALL 4
`define TDBD_SC_INHIBIT 5
`define TDBD_SC_VIEW 7

// ****************************************************************
// Channel mode fields
// ****************************************************************
`define TDBD_MD_SRC_DIR 0
`define TDBD_MD_SRC_EN 1
`define TDBD_MD_DST_DIR 2
`define TDBD_MD_DST_EN 3
`define TDBD_MD_LATCH_ONLY 4
`define TDBD_MD_STOP_UF 5
`define TDBD_MD_RELOAD 6
`define TDBD_MD_BURST 7
`define TDBD_MD_STORE_MASK 8'hbf

// ****************************************************************
// Request control fields
// ****************************************************************
`define TDBD_RQ_SEL_HI 3
`define TDBD_RQ_KICK 4
`define TDBD_RQ_PACE 5
`define TDBD_RQ_CLR 6
`define TDBD_RQ_ON 7
`define TDBD_RQ_STORE_MASK 8'haf

// ****************************************************************
// Reset values
// ****************************************************************
`define TDBD_RST_BYTE 8'h00
`define TDBD_RST_WORD 16'h0000

`endif

// file: src/tdbd_dma.v
// Two-channel byte DMA engine with register port and on-chip bus master
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`include "tdbd_defines.vh"

module tdbd_dma (
   // Clock and reset
   input wire core_clk,
   input wire reset,
   // Register port
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // Request sources, bit 0 of hw_src0 and hw_src1 unused
   input wire [15:0] hw_src0,
   input wire [15:0] hw_src1,
   input wire [1:0] pkt_done,
   // CPU handshake
   input wire cpu_iflag,
   input wire irq_req,
   output reg cpu_hold,
   // On-chip bus master
   output reg [15:0] mem_addr,
   output reg [7:0] mem_wdata,
   output reg mem_rd,
   output reg mem_wr,
   input wire [7:0] mem_rdata
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RD = 2'h1;
   localparam ST_DAT = 2'h2;
   localparam ST_WR = 2'h3;

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Post-transfer address update
   function [15:0] step_addr;
      input [15:0] a;
      input en;
      input dir;
      begin
         if (!en)
            step_addr = a;
         else if (dir)
            step_addr = a - 16'h0001;
         else
            step_addr = a + 16'h0001;
      end
   endfunction

   // Replace one byte of a word
   function [15:0] put_byte;
      input [15:0] old;
      input hi;
      input [7:0] b;
      begin
         put_byte = hi ? {b, old[7:0]} : {old[15:8], b};
      end
   endfunction

   // A channel may be given the bus
   function chan_ok;
      input on;
      input sf;
      input want;
      input burst;
      input blk_b;
      input blk_s;
      begin
         chan_ok = on & ~sf & want & ~(burst ? blk_b : blk_s);
      end
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   reg [7:0] mode_r [0:1];
   reg [7:0] rqc_r [0:1];
   reg [15:0] src_r [0:1];
   reg [15:0] dst_r [0:1];
   reg [15:0] cnt_r [0:1];
   reg [15:0] srcl_r [0:1];
   reg [15:0] dstl_r [0:1];
   reg [15:0] cntl_r [0:1];
   reg [15:0] sa_r [0:1];
   reg [15:0] sb_r [0:1];
   reg [1:0] selq_r;
   reg [1:0] uf_r;
   reg [1:0] sf_r;
   reg [1:0] pend_r;
   reg [1:0] busy_r;
   reg view_r;
   reg inhibit_r;
   reg susp_all_r;
   reg fair_r;
   reg iflag_q_r;
   reg cur_r;
   reg [1:0] state_r;
   reg [7:0] rd_nxt;
   integer i;

   // ****************************************************************
   // Combinational decode
   // ****************************************************************
   wire vc = view_r;
   wire [1:0] on = {rqc_r[1][`TDBD_RQ_ON], rqc_r[0][`TDBD_RQ_ON]};
   wire [1:0] burst = {mode_r[1][`TDBD_MD_BURST], mode_r[0][`TDBD_MD_BURST]};
   wire [3:0] sel0 = rqc_r[0][`TDBD_RQ_SEL_HI:0];
   wire [3:0] sel1 = rqc_r[1][`TDBD_RQ_SEL_HI:0];
   // Code zero picks no hardware line, so only the soft kick remains
   wire [1:0] hw_rise = {
      (sel1 != 4'h0) & sb_r[1][sel1] & ~selq_r[1],
      (sel0 != 4'h0) & sb_r[0][sel0] & ~selq_r[0]};
   // Bursts wait out interrupt service; singles only with suspend-all
   wire blk_b = cpu_iflag | irq_req;
   wire blk_s = susp_all_r & blk_b;
   wire [1:0] want = busy_r | pend_r;
   wire [1:0] elig = {
      chan_ok(on[1], sf_r[1], want[1], burst[1], blk_b, blk_s),
      chan_ok(on[0], sf_r[0], want[0], burst[0], blk_b, blk_s)};
   // Channel 0 wins unless channel 1 holds its fairness slot
   wire pick = (fair_r & elig[1]) | ~elig[0];
   wire [7:0] cmode = mode_r[cur_r];
   wire last = ~burst[cur_r] | (cnt_r[cur_r] == 16'h0000);
   wire [15:0] nsrc = step_addr(src_r[cur_r], cmode[`TDBD_MD_SRC_EN],
      cmode[`TDBD_MD_SRC_DIR]);
   wire [15:0] ndst = step_addr(dst_r[cur_r], cmode[`TDBD_MD_DST_EN],
      cmode[`TDBD_MD_DST_DIR]);
   wire pre0 = cur_r & elig[0];
   wire stop = last | pre0 | (cur_r & fair_r) | blk_b | ~on[cur_r];
   wire wr_hi = (reg_addr == `TDBD_OFS_SRC_HI) | (reg_addr == `TDBD_OFS_DST_HI) |
      (reg_addr == `TDBD_OFS_CNT_HI);
   wire latch_only = mode_r[vc][`TDBD_MD_LATCH_ONLY];
   wire iflag_fall = iflag_q_r & ~cpu_iflag;

   // Read multiplexer; write-only action bits read as zero
   always @* begin
      rd_nxt = 8'h00;
      case (reg_addr)
         `TDBD_OFS_STATUS: rd_nxt = {view_r, 1'b0, inhibit_r, susp_all_r,
            sf_r[1], uf_r[1], sf_r[0], uf_r[0]};
         `TDBD_OFS_MODE: rd_nxt = mode_r[vc] & `TDBD_MD_STORE_MASK;
         `TDBD_OFS_SRC_LO: rd_nxt = src_r[vc][7:0];
         `TDBD_OFS_SRC_HI: rd_nxt = src_r[vc][15:8];
         `TDBD_OFS_DST_LO: rd_nxt = dst_r[vc][7:0];
         `TDBD_OFS_DST_HI: rd_nxt = dst_r[vc][15:8];
         `TDBD_OFS_CNT_LO: rd_nxt = cnt_r[vc][7:0];
         `TDBD_OFS_CNT_HI: rd_nxt = cnt_r[vc][15:8];
         `TDBD_OFS_RQC0: rd_nxt = rqc_r[0];
         `TDBD_OFS_RQC1: rd_nxt = rqc_r[1];
         default: rd_nxt = 8'h00;
      endcase
   end

   // ****************************************************************
   // Registers, request capture and transfer engine
   // ****************************************************************

   // One process so hardware events are written last and beat software
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         for (i = 0; i < 2; i = i + 1) begin
            mode_r[i] <= `TDBD_RST_BYTE;
            rqc_r[i] <= `TDBD_RST_BYTE;
            src_r[i] <= `TDBD_RST_WORD;
            dst_r[i] <= `TDBD_RST_WORD;
            cnt_r[i] <= `TDBD_RST_WORD;
            srcl_r[i] <= `TDBD_RST_WORD;
            dstl_r[i] <= `TDBD_RST_WORD;
            cntl_r[i] <= `TDBD_RST_WORD;
            sa_r[i] <= `TDBD_RST_WORD;
            sb_r[i] <= `TDBD_RST_WORD;
         end
         selq_r <= 2'h0;
         uf_r <= 2'h0;
         sf_r <= 2'h0;
         pend_r <= 2'h0;
         busy_r <= 2'h0;
         view_r <= 1'b0;
         inhibit_r <= 1'b0;
         susp_all_r <= 1'b0;
         fair_r <= 1'b0;
         iflag_q_r <= 1'b0;
         cur_r <= 1'b0;
         state_r <= ST_IDLE;
         reg_rdata <= 8'h00;
         cpu_hold <= 1'b0;
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_nxt : 8'h00;
         iflag_q_r <= cpu_iflag;

         // Two-stage capture of request lines, then edge memory
         for (i = 0; i < 2; i = i + 1) begin
            sa_r[i] <= (i == 0) ? hw_src0 : hw_src1;
            sb_r[i] <= sa_r[i];
         end
         selq_r <= {sb_r[1][sel1], sb_r[0][sel0]};

         // Returning from interrupt service releases suspended channels
         if (iflag_fall)
            sf_r <= 2'h0;

         // Status/config: underflow flags clear by writing zero
         if (reg_wr && reg_addr == `TDBD_OFS_STATUS) begin
            uf_r <= uf_r & {reg_wdata[`TDBD_SC_UF1], reg_wdata[`TDBD_SC_UF0]};
            susp_all_r <= reg_wdata[`TDBD_SC_SUSP_ALL];
            inhibit_r <= reg_wdata[`TDBD_SC_INHIBIT];
            view_r <= reg_wdata[`TDBD_SC_VIEW];
         end

         // Mode register of the viewed channel; reload bit is an action
         if (reg_wr && reg_addr == `TDBD_OFS_MODE) begin
            mode_r[vc] <= reg_wdata & `TDBD_MD_STORE_MASK;
            if (reg_wdata[`TDBD_MD_RELOAD]) begin
               src_r[vc] <= srcl_r[vc];
               dst_r[vc] <= dstl_r[vc];
               cnt_r[vc] <= cntl_r[vc];
            end
         end

         // Address and count bytes land in the latch, and in the live copy unless latch-only is set
         if (reg_wr) begin
            case (reg_addr)
               `TDBD_OFS_SRC_LO, `TDBD_OFS_SRC_HI: begin
                  srcl_r[vc] <= put_byte(srcl_r[vc], wr_hi, reg_wdata);
                  if (!latch_only)
                     src_r[vc] <= put_byte(src_r[vc], wr_hi, reg_wdata);
               end
               `TDBD_OFS_DST_LO, `TDBD_OFS_DST_HI: begin
                  dstl_r[vc] <= put_byte(dstl_r[vc], wr_hi, reg_wdata);
                  if (!latch_only)
                     dst_r[vc] <= put_byte(dst_r[vc], wr_hi, reg_wdata);
               end
               `TDBD_OFS_CNT_LO, `TDBD_OFS_CNT_HI: begin
                  cntl_r[vc] <= put_byte(cntl_r[vc], wr_hi, reg_wdata);
                  if (!latch_only)
                     cnt_r[vc] <= put_byte(cnt_r[vc], wr_hi, reg_wdata);
               end
               default: begin
               end
            endcase
         end

         // Request control: enable, pacing, source select and actions
         for (i = 0; i < 2; i = i + 1) begin
            if (reg_wr && reg_addr == ((i == 0) ? `TDBD_OFS_RQC0 : `TDBD_OFS_RQC1)) begin
               rqc_r[i] <= reg_wdata & `TDBD_RQ_STORE_MASK;
               if (reg_wdata[`TDBD_RQ_CLR])
                  pend_r[i] <= 1'b0;
               if (reg_wdata[`TDBD_RQ_ON] && sf_r[i])
                  sf_r[i] <= 1'b0;
            end
         end

         // Packet completion of a paced channel
         for (i = 0; i < 2; i = i + 1) begin
            if (pkt_done[i] && rqc_r[i][`TDBD_RQ_PACE]) begin
               if (!inhibit_r) begin
                  src_r[i] <= srcl_r[i];
                  dst_r[i] <= dstl_r[i];
                  cnt_r[i] <= cntl_r[i];
               end
               if (mode_r[i][`TDBD_MD_STOP_UF])
                  rqc_r[i][`TDBD_RQ_ON] <= 1'b0;
            end
         end

         // Transfer engine; the bus is grabbed only by a channel that interrupt service does not block
         case (state_r)
            ST_IDLE: begin
               // CPU owns this cycle, which spaces distinct transfers
               cpu_hold <= 1'b0;
               mem_rd <= 1'b0;
               mem_wr <= 1'b0;
               if (fair_r && !elig[1])
                  fair_r <= 1'b0;
               if (|elig) begin
                  cur_r <= pick;
                  if (!busy_r[pick]) begin
                     pend_r[pick] <= 1'b0;
                     busy_r[pick] <= 1'b1;
                  end
                  mem_addr <= src_r[pick];
                  mem_rd <= 1'b1;
                  cpu_hold <= 1'b1;
                  state_r <= ST_RD;
               end
            end
            ST_RD: begin
               mem_rd <= 1'b0;
               state_r <= ST_DAT;
            end
            ST_DAT: begin
               mem_addr <= dst_r[cur_r];
               mem_wdata <= mem_rdata;
               mem_wr <= 1'b1;
               state_r <= ST_WR;
            end
            ST_WR: begin
               mem_wr <= 1'b0;
               src_r[cur_r] <= nsrc;
               dst_r[cur_r] <= ndst;
               if (cnt_r[cur_r] == 16'h0000) begin
                  // Underflow restores the channel for its next run
                  uf_r[cur_r] <= 1'b1;
                  src_r[cur_r] <= srcl_r[cur_r];
                  dst_r[cur_r] <= dstl_r[cur_r];
                  cnt_r[cur_r] <= cntl_r[cur_r];
               end else begin
                  cnt_r[cur_r] <= cnt_r[cur_r] - 16'h0001;
               end
               if (cur_r)
                  fair_r <= 1'b0;
               if (last) begin
                  busy_r[cur_r] <= 1'b0;
                  if (!cur_r && burst[0] && busy_r[1])
                     fair_r <= 1'b1;
               end else if (irq_req && !cpu_iflag) begin
                  sf_r[cur_r] <= 1'b1;
               end
               if (stop) begin
                  // Suspended bursts keep busy and resume where they stopped
                  cpu_hold <= 1'b0;
                  state_r <= ST_IDLE;
               end else begin
                  mem_addr <= nsrc;
                  mem_rd <= 1'b1;
                  state_r <= ST_RD;
               end
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase

         // Requests caught now survive a clear in the same cycle
         for (i = 0; i < 2; i = i + 1) begin
            if (hw_rise[i])
               pend_r[i] <= 1'b1;
            if (reg_wr && reg_wdata[`TDBD_RQ_KICK] &&
                reg_addr == ((i == 0) ? `TDBD_OFS_RQC0 : `TDBD_OFS_RQC1))
               pend_r[i] <= 1'b1;
         end
      end
   end

endmodule

// file: verification/tdbd_mem_model.sv
// Behavioural on-chip memory answering the DMA bus master
`timescale 1ns/10ps
module tdbd_mem_model (
   // Clock and reset
   input logic core_clk,
   input logic reset,
   // Bus from the DMA
   input logic [15:0] mem_addr,
   input logic [7:0] mem_wdata,
   input logic mem_rd,
   input logic mem_wr,
   output logic [7:0] mem_rdata
);
   logic [7:0] store [int];

   // Answer one cycle after the read; between answers the line toggles so stale data shows
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mem_rdata <= 8'h00;
      end else if (mem_rd) begin
         mem_rdata <= store.exists(mem_addr) ? store[mem_addr] :
            (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c);
      end else begin
         mem_rdata <= ~mem_rdata;
      end
      if (!reset && mem_wr) begin
         store[mem_addr] = mem_wdata;
      end
   end
endmodule

// file: verification/tdbd_dma_properties.sv
// Port-level checker of the two-channel byte DMA
`timescale 1ns/10ps
`include "tdbd_defines.vh"
module tdbd_dma_properties (
   // Clock and reset
   input logic core_clk,
   input logic reset,
   // Register port
   input logic [7:0] reg_addr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   // Bus side
   input logic cpu_hold,
   input logic [15:0] mem_addr,
   input logic [7:0] mem_wdata,
   input logic mem_rd,
   input logic mem_wr,
   input logic [7:0] mem_rdata
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // ****************************************************************
   // Byte pair: read, wait, write
   // ****************************************************************
   sequence seq_pair;
      mem_rd ##1 (!mem_rd && !mem_wr) ##1 mem_wr;
   endsequence
   sequence seq_hold_end;
      $past(mem_wr, 1) || $past(mem_wr, 2);
   endsequence

   AST_PAIR: assert property (mem_rd |-> seq_pair)
      else $error("read not followed by write two cycles later");
   AST_WR_ORIGIN: assert property (mem_wr |-> $past(mem_rd, 2))
      else $error("write without read two cycles before");
   AST_WR_DATA: assert property (mem_wr |-> mem_wdata == $past(mem_rdata))
      else $error("written byte differs from byte read");
   AST_HOLD_BUS: assert property ((mem_rd || mem_wr) |-> cpu_hold)
      else $error("bus strobe while cpu owns bus");
   AST_HOLD_START: assert property ($rose(cpu_hold) |-> mem_rd)
      else $error("bus taken without a read");
   AST_HOLD_END: assert property ($fell(cpu_hold) |-> seq_hold_end)
      else $error("bus returned in mid pair");
   AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   AST_RELOAD_ZERO: assert property (reg_rd && reg_addr == `TDBD_OFS_MODE |=> !reg_rdata[6])
      else $error("reload bit read as one");
   AST_KICK_ZERO: assert property (reg_rd && (reg_addr == `TDBD_OFS_RQC0 ||
      reg_addr == `TDBD_OFS_RQC1) |=> reg_rdata[4] == 1'b0 && !reg_rdata[6])
      else $error("action bits read as one");
endmodule

bind tdbd_dma tdbd_dma_properties i_props (.core_clk, .reset, .reg_addr, .reg_rd,
   .reg_rdata, .cpu_hold, .mem_addr, .mem_wdata, .mem_rd, .mem_wr, .mem_rdata);

// file: verification/tdbd_dma_tb_top.sv
// Self-checking bench of the two-channel byte DMA
`timescale 1ns/10ps
`include "tdbd_defines.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tdbd_dma_tb_top;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rv, mem_wdata, mem_rdata;
   logic reg_wr = 1'b0, reg_rd = 1'b0, cpu_iflag = 1'b0, irq_req = 1'b0, susp = 1'b0;
   logic [15:0] hw_src0 = 16'h0000, mem_addr, s;
   logic [15:0] hw_src1 = 16'h0000;
   logic [1:0] pkt_done = 2'b00;
   logic cpu_hold, mem_rd, mem_wr;
   logic [23:0] exp_q[$];
   logic [23:0] exp_w;
   logic [31:0] seed = 32'ha66b;
   logic [3:0] code;
   logic [7:0] al [11] = '{8'h3f, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
      8'h47, 8'h48, 8'h50};
   int n_mismatch = 0;
   int samples_checked = 0;
   int j;

   // ****************************************************************
   // Design, far side and stimulus helpers
   // ****************************************************************
   tdbd_dma i_dut (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .hw_src0(hw_src0), .hw_src1(hw_src1), .pkt_done(pkt_done), .cpu_iflag(cpu_iflag),
      .irq_req(irq_req), .cpu_hold(cpu_hold), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata));
   tdbd_mem_model i_mem (.core_clk(core_clk), .reset(reset), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata));

   always #12.5 core_clk = ~core_clk;

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      // Data stands for the cycle after the strobe; take it at that cycle's closing edge
      @(posedge core_clk);
      d = reg_rdata;
   endtask
   task automatic prog(input logic ch, input logic [15:0] a, d, c, input logic [7:0] m);
      wr(`TDBD_OFS_STATUS, {ch, 1'b0, 1'b0, susp, 4'h0}); // Reserved bit kept zero
      wr(`TDBD_OFS_SRC_LO, a[7:0]);
      wr(`TDBD_OFS_SRC_HI, a[15:8]);
      wr(`TDBD_OFS_DST_LO, d[7:0]);
      wr(`TDBD_OFS_DST_HI, d[15:8]);
      wr(`TDBD_OFS_CNT_LO, c[7:0]);
      wr(`TDBD_OFS_CNT_HI, c[15:8]);
      wr(`TDBD_OFS_MODE, m);
   endtask
   // Reference model: the byte image of a source address lands at the stepping destination
   task automatic run(input logic [15:0] a, d, input int n, input logic sd, dd);
      repeat (n) begin
         exp_q.push_back({d, a[7:0] ^ a[15:8] ^ 8'h3c});
         a = sd ? a - 16'h1 : a + 16'h1;
         d = dd ? d - 16'h1 : d + 16'h1;
      end
   endtask
   // Bounded wait until every expected byte moved and the bus is back with the cpu
   task automatic settle;
      int k = 0;
      while ((exp_q.size() != 0 || cpu_hold !== 1'b0) && k < 400) begin
         @(posedge core_clk);
         k++;
      end
      `CHK("transfer finished", 1'b1, k < 400)
      repeat (3) @(posedge core_clk);
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Every bus write is compared in order with the model; order proves priority too
   always @(posedge core_clk) begin
      if (mem_wr === 1'b1) begin
         exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 24'hffffff;
         `CHK("bus write", exp_w, {mem_addr, mem_wdata})
      end
   end

   // Watchdog sized well beyond the whole sequence
   initial begin
      #500000;
      n_mismatch++;
      complete_run;
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      for (j = 0; j < 11; j++) begin
         rd(al[j], rv);
         `CHK("reset value", 8'h00, rv)
      end
      $display("test reset values done");
      seed = xs(seed);
      s = {8'h10, seed[7:0]};
      prog(1'b0, s, 16'h8000, 16'h0002, 8'h0a);
      run(s, 16'h8000, 1, 1'b0, 1'b0);
      wr(`TDBD_OFS_RQC0, 8'h90);
      settle;
      rd(`TDBD_OFS_CNT_LO, rv);
      `CHK("count after single", 8'h01, rv)
      rd(`TDBD_OFS_SRC_LO, rv);
      `CHK("source step", s[7:0] + 8'h01, rv)
      rd(`TDBD_OFS_RQC0, rv);
      `CHK("request control", 8'h80, rv)
      wr(`TDBD_OFS_MODE, 8'h4a);
      rd(`TDBD_OFS_SRC_LO, rv);
      `CHK("manual reload", s[7:0], rv)
      rd(`TDBD_OFS_MODE, rv);
      `CHK("mode readback", 8'h0a, rv)
      $display("test single transfer done");
      prog(1'b0, s, 16'h80ff, 16'h0003, 8'h8f);
      run(s, 16'h80ff, 4, 1'b1, 1'b1);
      wr(`TDBD_OFS_RQC0, 8'h90);
      settle;
      rd(`TDBD_OFS_STATUS, rv);
      `CHK("underflow flag", 1'b1, rv[0])
      rd(`TDBD_OFS_SRC_LO, rv);
      `CHK("reload on underflow", s[7:0], rv)
      $display("test burst done");
      wr(`TDBD_OFS_RQC0, 8'h10);
      repeat (20) @(posedge core_clk);
      `CHK("idle while off", 1'b0, cpu_hold)
      wr(`TDBD_OFS_RQC0, 8'h40);
      wr(`TDBD_OFS_RQC0, 8'h80);
      repeat (20) @(posedge core_clk);
      `CHK("latch cleared", 1'b0, cpu_hold)
      $display("test enable and latch clear done");
      susp = 1'b1;
      cpu_iflag <= 1'b1;
      prog(1'b1, 16'h2000, 16'h9000, 16'h0000, 8'h0a);
      prog(1'b0, 16'h3000, 16'ha000, 16'h0000, 8'h0a);
      run(16'h3000, 16'ha000, 1, 1'b0, 1'b0);
      run(16'h2000, 16'h9000, 1, 1'b0, 1'b0);
      wr(`TDBD_OFS_RQC1, 8'h90);
      wr(`TDBD_OFS_RQC0, 8'h90);
      repeat (10) @(posedge core_clk);
      `CHK("single held", 1'b0, cpu_hold)
      cpu_iflag <= 1'b0;
      settle;
      $display("test priority done");
      susp = 1'b0;
      prog(1'b1, 16'h2100, 16'h9100, 16'h0005, 8'h8a);
      run(16'h2100, 16'h9100, 6, 1'b0, 1'b0);
      wr(`TDBD_OFS_RQC1, 8'h90);
      for (j = 0; j < 50 && mem_wr !== 1'b1; j++) @(posedge core_clk);
      irq_req <= 1'b1;
      repeat (4) @(posedge core_clk);
      cpu_iflag <= 1'b1;
      irq_req <= 1'b0;
      repeat (10) @(posedge core_clk);
      `CHK("burst suspended", 1'b0, cpu_hold)
      `CHK("bytes left", 1'b1, exp_q.size() != 0)
      rd(`TDBD_OFS_STATUS, rv);
      `CHK("suspend flag set", 1'b1, rv[3])
      cpu_iflag <= 1'b0;
      settle;
      rd(`TDBD_OFS_STATUS, rv);
      `CHK("suspend flag cleared", 1'b0, rv[3])
      $display("test interrupt suspend done");
      seed = xs(seed);
      code = seed[3:0] | 4'h1;
      prog(1'b0, 16'h3100, 16'ha100, 16'h0000, 8'h0a);
      run(16'h3100, 16'ha100, 1, 1'b0, 1'b0);
      wr(`TDBD_OFS_RQC0, {4'h8, code});
      hw_src0[code] <= 1'b1;
      settle;
      hw_src0 <= 16'h0000;
      $display("test hardware request done");
      // Channel 1 burst from a hardware line, pre-empted twice by channel 0 bursts
      prog(1'b0, 16'h3200, 16'ha200, 16'h0001, 8'h8a);
      prog(1'b1, 16'h2200, 16'h9200, 16'h0005, 8'h8a);
      run(16'h2200, 16'h9200, 2, 1'b0, 1'b0);
      run(16'h3200, 16'ha200, 2, 1'b0, 1'b0);
      run(16'h2202, 16'h9202, 1, 1'b0, 1'b0);
      run(16'h3200, 16'ha200, 2, 1'b0, 1'b0);
      run(16'h2203, 16'h9203, 3, 1'b0, 1'b0);
      wr(`TDBD_OFS_RQC1, {4'h8, code});
      hw_src1[code] <= 1'b1;
      for (j = 0; j < 50 && mem_wr !== 1'b1; j++) @(posedge core_clk);
      wr(`TDBD_OFS_RQC0, 8'h90);
      wr(`TDBD_OFS_RQC0, 8'h90); // Second request lands as the first starts
      settle;
      hw_src1 <= 16'h0000;
      $display("test pre-emption done");
      // Packet completion: reload inhibited, then allowed; enable dropped after the first
      prog(1'b0, 16'h3300, 16'ha300, 16'h0004, 8'h2a);
      run(16'h3300, 16'ha300, 1, 1'b0, 1'b0);
      wr(`TDBD_OFS_RQC0, 8'h90);
      settle;
      wr(`TDBD_OFS_STATUS, 8'h20);
      wr(`TDBD_OFS_RQC0, 8'ha0);
      pkt_done <= 2'b01;
      @(posedge core_clk);
      pkt_done <= 2'b00;
      rd(`TDBD_OFS_SRC_LO, rv);
      `CHK("reload inhibited", 8'h01, rv)
      rd(`TDBD_OFS_RQC0, rv);
      `CHK("stop after packet", 8'h20, rv)
      wr(`TDBD_OFS_STATUS, 8'h00);
      pkt_done <= 2'b01;
      @(posedge core_clk);
      pkt_done <= 2'b00;
      rd(`TDBD_OFS_SRC_LO, rv);
      `CHK("packet reload", 8'h00, rv)
      $display("test packet completion done");
      complete_run;
   end
endmodule
